/* File: src/spiee_pkg.sv */
// What this block does
// - each instruction is shifted into an 8-bit register and decoded to six operations.
// - opcode, address and data bits travel most significant bit first.
// - array read 03h, array write 02h, status read 05h, status write 01h.
// - set write latch 06h, clear write latch 04h.
// - 8-bit status register; only the low four bits mean anything.
// - bits 3..2 block protect, bit 1 write latch, bit 0 busy; 1..0 read-only.
// - during programming only the busy bit of a status read is valid.
// - writes need protect pin high and latch set; protected blocks stay blocked.
// - serial traffic accepted only while selected and not suspended.
// - input sampled on sck rising edges from selection; output off meanwhile.
// - reads drive output after each falling edge once input ends; input then ignored.
// - modes 0 and 3: sample on rising, change output after falling edges.
// - suspend entered only with sck low, else at the next sck falling edge.
// - while suspended ignore sck and input, output off, keep all sequence state.
// - suspend left only with sck low, else at the next sck falling edge.
// - output goes high impedance at once whenever suspend pin is low.
// - only address bits 10..0 are used; 15..11 are ignored.
// - read address increments per byte and wraps from last to first location.
// - status read sends opcode only; status shifts out bit 7 down to bit 0.
// - protect code 00 none, 01 600-7FF, 10 400-7FF, 11 000-7FF.
// - write latch starts cleared, so set-latch must precede any write.
// - status write stores only data bits 3 and 2.
// - write latch clears when an array or status write cycle completes; here it clears at deselect, as the cycle starts.
package spiee_pkg;

    // =====================================================
    // opcodes
    localparam logic [7:0] SET_WRITE_LATCH_OP   = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_OP = 8'h04;
    localparam logic [7:0] STATUS_READ_OP       = 8'h05;
    localparam logic [7:0] STATUS_WRITE_OP      = 8'h01;
    localparam logic [7:0] ARRAY_READ_OP        = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_OP       = 8'h02;

    // =====================================================
    // array and status layout
    localparam int ADDR_W    = 11;
    localparam int MEM_BYTES = 2048;
    localparam int PAGE_W    = 4;
    localparam int SR_BUSY   = 0;
    localparam int SR_WEL    = 1;
    localparam int SR_BP_LO  = 2;
    localparam int SR_BP_HI  = 3;
    localparam logic [1:0] BP_NONE  = 2'h0;
    localparam logic [1:0] BP_QUART = 2'h1;
    localparam logic [1:0] BP_HALF  = 2'h2;
    localparam logic [1:0] BP_ALL   = 2'h3;
    localparam logic [3:0] SR_UNUSED = 4'h0;

    // =====================================================
    // pin vector positions and idle levels
    localparam int NPINS    = 5;
    localparam int PIN_CS   = 0;
    localparam int PIN_SCK  = 1;
    localparam int PIN_SI   = 2;
    localparam int PIN_HOLD = 3;
    localparam int PIN_WP   = 4;
    localparam logic [4:0] PINS_IDLE = 5'h19;

    // =====================================================
    // timing
    localparam int T_WP_MS = 15;
    localparam int CLK_KHZ = 125000;
    localparam int PROG_CYCLES_DEF = T_WP_MS * CLK_KHZ;
    localparam int BUSY_W = 24;

    typedef enum logic [2:0] {
        SPIEE_PH_IDLE   = 3'b000,
        SPIEE_PH_OPCODE = 3'b001,
        SPIEE_PH_ADDR   = 3'b010,
        SPIEE_PH_DATA   = 3'b011,
        SPIEE_PH_ARR_RD = 3'b100,
        SPIEE_PH_SR_RD  = 3'b101
    } spiee_phase_t;

endpackage

/* File: src/spiee_core.sv */
module spiee_core #(
    parameter int PROG_CYCLES = spiee_pkg::PROG_CYCLES_DEF
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // spi pins from the master
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    // serial output pin
    output logic      so,
    output logic      so_oe,
    // programming in progress
    output logic      busy
);

    // =====================================================
    // parameter check: the busy counter must hold the whole programming time
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << spiee_pkg::BUSY_W)) begin : g_prog_range
        $error("PROG_CYCLES out of range");
    end

    typedef struct packed {
        logic [4:0]                s1;
        logic [4:0]                s2;
        logic [4:0]                s3;
        logic [4:0]                pin;
        logic                      held;
        spiee_pkg::spiee_phase_t   ph;
        logic [2:0]                bitcnt;
        logic [7:0]                sh;
        logic [7:0]                op;
        logic [7:0]                out;
        logic                      addr_lo;
        logic [10:0]               addr;
        logic [10:0]               fa;
        logic                      rq;
        logic [1:0][7:0]           fd;
        logic                      fw;
        logic                      fr;
        logic [1:0]                cnt;
        logic                      so;
        logic                      oe;
        logic                      wel;
        logic [1:0]                bp;
        logic [1:0]                bp_pend;
        logic                      sw_pend;
        logic                      aw_pend;
        logic [23:0]               busy_cnt;
    } spiee_state_t;

    spiee_state_t r;
    spiee_state_t n;

    logic [7:0]  mem [spiee_pkg::MEM_BYTES];
    logic [7:0]  mem_q;
    logic        mem_we;
    logic [10:0] mem_wa;
    logic [7:0]  mem_wd;

    // =====================================================
    // next state
    always_comb begin
        logic [4:0] agree;
        logic       cs_fall;
        logic       cs_rise;
        logic       sck_rise;
        logic       sck_fall;
        logic       go;
        logic       busy_now;
        logic       wr_ok;
        logic       prot;
        logic       push;
        logic       pop;
        logic       issue;
        logic [7:0] b;
        logic [7:0] ob;
        logic [7:0] sr;
        agree    = '0;
        cs_fall  = 1'b0;
        cs_rise  = 1'b0;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        go       = 1'b0;
        busy_now = 1'b0;
        wr_ok    = 1'b0;
        prot     = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        issue    = 1'b0;
        b        = '0;
        ob       = '0;
        sr       = '0;
        n        = r;
        mem_we   = 1'b0;
        mem_wa   = r.addr;
        mem_wd   = '0;

        // pins: a change counts once the second and third stages agree
        n.s1  = {wp_n, hold_n, si, sck, cs_n};
        n.s2  = r.s1;
        n.s3  = r.s2;
        agree = ~(r.s2 ^ r.s3);
        n.pin = (agree & r.s3) | (~agree & r.pin);

        cs_fall  = r.pin[spiee_pkg::PIN_CS] & ~n.pin[spiee_pkg::PIN_CS];
        cs_rise  = ~r.pin[spiee_pkg::PIN_CS] & n.pin[spiee_pkg::PIN_CS];
        sck_rise = ~r.pin[spiee_pkg::PIN_SCK] & n.pin[spiee_pkg::PIN_SCK];
        sck_fall = r.pin[spiee_pkg::PIN_SCK] & ~n.pin[spiee_pkg::PIN_SCK];

        busy_now = (r.busy_cnt != '0);
        if (busy_now) begin
            n.busy_cnt = r.busy_cnt - 24'h000001;
        end
        wr_ok = n.pin[spiee_pkg::PIN_WP] & r.wel;
        case (r.bp)
            spiee_pkg::BP_QUART: prot = (r.addr[10:9] == 2'h3);
            spiee_pkg::BP_HALF:  prot = r.addr[10];
            spiee_pkg::BP_ALL:   prot = 1'b1;
            default:             prot = 1'b0;
        endcase
        sr = {spiee_pkg::SR_UNUSED, r.bp, r.wel, busy_now};

        // suspend changes state only while sck is low
        if (!n.pin[spiee_pkg::PIN_CS] && !n.pin[spiee_pkg::PIN_SCK]) begin
            n.held = ~n.pin[spiee_pkg::PIN_HOLD];
        end
        // a suspended part ignores every sck edge and keeps its state
        go = ~n.pin[spiee_pkg::PIN_CS] & ~r.held & ~n.held;

        // =====================================================
        // read prefetch into the two-entry buffer
        push = r.rq;
        if (push) begin
            n.fd[r.fw] = mem_q;
            n.fw       = ~r.fw;
        end
        // at most two bytes in flight, so a falling edge never waits on the array
        issue = (r.ph == spiee_pkg::SPIEE_PH_ARR_RD) && ({1'b0, r.rq} + r.cnt < 2'h2);
        n.rq  = issue;
        if (issue) begin
            n.fa = r.fa + 11'h001;
        end

        // =====================================================
        // input bits on rising edges
        if (go && sck_rise && r.ph != spiee_pkg::SPIEE_PH_ARR_RD
                && r.ph != spiee_pkg::SPIEE_PH_SR_RD && r.ph != spiee_pkg::SPIEE_PH_IDLE) begin
            b        = {r.sh[6:0], n.pin[spiee_pkg::PIN_SI]};
            n.sh     = b;
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
                case (r.ph)
                    spiee_pkg::SPIEE_PH_OPCODE: begin
                        n.op = b;
                        n.ph = spiee_pkg::SPIEE_PH_IDLE;
                        // while programming, only the status read is honoured
                        if (b == spiee_pkg::STATUS_READ_OP) begin
                            n.ph = spiee_pkg::SPIEE_PH_SR_RD;
                        end else if (!busy_now) begin
                            case (b)
                                spiee_pkg::SET_WRITE_LATCH_OP:   n.wel = 1'b1;
                                spiee_pkg::CLEAR_WRITE_LATCH_OP: n.wel = 1'b0;
                                spiee_pkg::STATUS_WRITE_OP:      n.ph = spiee_pkg::SPIEE_PH_DATA;
                                spiee_pkg::ARRAY_READ_OP, spiee_pkg::ARRAY_WRITE_OP: begin
                                    n.ph      = spiee_pkg::SPIEE_PH_ADDR;
                                    n.addr_lo = 1'b0;
                                end
                                default: n.ph = spiee_pkg::SPIEE_PH_IDLE;
                            endcase
                        end
                    end
                    spiee_pkg::SPIEE_PH_ADDR: begin
                        if (!r.addr_lo) begin
                            n.addr[10:8] = b[2:0];
                            n.addr_lo    = 1'b1;
                        end else begin
                            n.addr[7:0] = b;
                            if (r.op == spiee_pkg::ARRAY_READ_OP) begin
                                n.ph  = spiee_pkg::SPIEE_PH_ARR_RD;
                                n.fa  = {r.addr[10:8], b};
                                n.rq  = 1'b0;
                                n.cnt = '0;
                                n.fw  = 1'b0;
                                n.fr  = 1'b0;
                                push  = 1'b0;
                            end else begin
                                n.ph = spiee_pkg::SPIEE_PH_DATA;
                            end
                        end
                    end
                    spiee_pkg::SPIEE_PH_DATA: begin
                        if (r.op == spiee_pkg::STATUS_WRITE_OP) begin
                            if (wr_ok) begin
                                n.bp_pend = b[spiee_pkg::SR_BP_HI:spiee_pkg::SR_BP_LO];
                                n.sw_pend = 1'b1;
                            end
                        end else if (wr_ok && !prot) begin
                            mem_we      = 1'b1;
                            mem_wd      = b;
                            n.aw_pend   = 1'b1;
                            n.addr[3:0] = r.addr[3:0] + 4'h1;
                        end
                    end
                    default: n.ph = spiee_pkg::SPIEE_PH_IDLE;
                endcase
            end
        end

        // =====================================================
        // output bits after falling edges
        if (go && sck_fall && (r.ph == spiee_pkg::SPIEE_PH_ARR_RD
                || r.ph == spiee_pkg::SPIEE_PH_SR_RD)) begin
            n.oe     = 1'b1;
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h0) begin
                if (r.ph == spiee_pkg::SPIEE_PH_SR_RD) begin
                    ob = sr;
                end else begin
                    ob  = r.fd[r.fr];
                    pop = (r.cnt != 2'h0);
                end
                n.so  = ob[7];
                n.out = {ob[6:0], 1'b0};
            end else begin
                n.so  = r.out[7];
                n.out = {r.out[6:0], 1'b0};
            end
        end
        if (pop) begin
            n.fr = ~r.fr;
        end
        if (r.ph == spiee_pkg::SPIEE_PH_ARR_RD || n.ph != spiee_pkg::SPIEE_PH_ARR_RD) begin
            n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
        end

        // =====================================================
        // select edges
        // programming starts only at deselect, and only after an accepted data byte
        if (cs_rise) begin
            n.ph = spiee_pkg::SPIEE_PH_IDLE;
            n.oe = 1'b0;
            n.rq = 1'b0;
            if (r.sw_pend || r.aw_pend) begin
                n.busy_cnt = PROG_CYCLES[23:0];
                n.wel      = 1'b0;
                if (r.sw_pend) begin
                    n.bp = r.bp_pend;
                end
            end
            n.sw_pend = 1'b0;
            n.aw_pend = 1'b0;
        end
        if (cs_fall) begin
            n.ph      = spiee_pkg::SPIEE_PH_OPCODE;
            n.bitcnt  = '0;
            n.held    = 1'b0;
            n.oe      = 1'b0;
            n.rq      = 1'b0;
            n.cnt     = '0;
            n.fw      = 1'b0;
            n.fr      = 1'b0;
            n.sw_pend = 1'b0;
            n.aw_pend = 1'b0;
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge clock) begin
        if (srst) begin
            // samplers start at the idle levels, so reset makes no false edge
            r      <= '0;
            r.s1   <= spiee_pkg::PINS_IDLE;
            r.s2   <= spiee_pkg::PINS_IDLE;
            r.s3   <= spiee_pkg::PINS_IDLE;
            r.pin  <= spiee_pkg::PINS_IDLE;
            r.wel  <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // =====================================================
    // array storage; not reset, content survives srst
    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        mem_q <= mem[r.fa];
    end

    // =====================================================
    // outputs; suspend cuts the driver without waiting for sck
    assign so    = r.so;
    assign so_oe = r.oe & ~r.held & r.pin[spiee_pkg::PIN_HOLD] & ~r.pin[spiee_pkg::PIN_CS];
    assign busy  = (r.busy_cnt != '0);

endmodule // spiee_core

/* File: testbench/spiee_core_chk.sv */
module spiee_core_chk #(
    parameter int PROG_CYCLES = 200
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // link pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    // device outputs
    input wire logic so,
    input wire logic so_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    int busy_cnt_reg;
    always_ff @(posedge clock) begin
        busy_cnt_reg <= (srst || !busy) ? 0 : busy_cnt_reg + 1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ==========================================
    // pin patterns; the hold and deselect ones long enough to pass the input synchronisers, the select start a single edge
    sequence s_hold_seen;
        !hold_n [*8];
    endsequence
    sequence s_desel_seen;
        cs_n [*8];
    endsequence
    sequence s_sel_start;
        $fell(cs_n);
    endsequence
    // ==========================================
    // properties
    AST_HOLD_OFF: assert property (s_hold_seen |-> !so_oe)
        else $error("so driven while suspended");
    AST_DESEL_OFF: assert property (s_desel_seen |-> !so_oe)
        else $error("so driven while deselected");
    AST_INPUT_QUIET: assert property (s_sel_start |-> !so_oe [*8])
        else $error("so driven during opcode input");
    AST_SO_ON_LOW: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
        else $error("so changed while sck high");
    AST_OE_RISE: assert property ($rose(so_oe) |-> !sck && !cs_n && hold_n)
        else $error("so enabled at wrong moment");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_reg == PROG_CYCLES)
        else $error("busy length wrong");
    AST_BUSY_START: assert property ($rose(busy) |-> cs_n && $past(cs_n, 3))
        else $error("busy began while selected");
    AST_BUSY_WP: assert property ($rose(busy) |-> wp_n && $past(wp_n, 8))
        else $error("programming began with protect pin low");
endmodule // spiee_core_chk

bind spiee_core spiee_core_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clock(clock), .srst(srst), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy));

/* File: testbench/spiee_master.sv */
module spiee_master (
    // system clock, used only to start frames
    input wire logic clock,
    // device output
    input wire logic so,
    input wire logic so_oe,
    // master pins
    output logic     cs_n,
    output logic     sck,
    output logic     si,
    output logic     hold_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n = 1;
        sck = 0;
        si = 0;
        hold_n = 1;
    end
    // sck low 40 ns and high 24 ns: the device answers some 4 clocks after a fall
    task automatic frame(input bit m3, input int hold_at, input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        @(posedge clock);
        #2 sck = m3;
        #8 cs_n = 0;
        #40;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                sck = 0;
                si = tx[k][i];
                #40 sck = 1;
                // a released line shows the inverse of its last value
                b[i] = so_oe ? so : ~so;
                #24;
                if (k == hold_at && i == 4) begin
                    sck = 0;
                    #8 hold_n = 0;
                    repeat (2) begin
                        #16 sck = 1;
                        si = ~si;
                        #16 sck = 0;
                    end
                    #16 hold_n = 1;
                    #16;
                end
            end
            rx.push_back(b);
        end
        if (!m3) sck = 0;
        #24 cs_n = 1;
        #96;
    endtask
endmodule // spiee_master

/* File: testbench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 200;
    logic        clock, srst, wp_n, cs_n, sck, si, hold_n, so, so_oe, busy;
    int          fails, n_compared;
    logic [31:0] seed = 32'h0000005C;
    logic [7:0]  mem [2048];
    logic [7:0]  rx[$];
    logic [7:0]  d;
    logic [1:0]  bp;
    bit          ok;
    logic [10:0] addrs[6] = '{11'h7FF, 11'h600, 11'h5FF, 11'h400, 11'h3FF, 11'h000};

    spiee_core #(.PROG_CYCLES(PROG)) dut_u (.clock(clock), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy));
    spiee_master m_u (.clock(clock), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

    initial begin
        clock = 0;
        forever #4 clock = ~clock;
    end
    // ==========================================
    // expectations
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic bit prot(logic [1:0] p, logic [10:0] a);
        return p == 2'h3 || (p == 2'h2 && a >= 11'h400) || (p == 2'h1 && a >= 11'h600);
    endfunction
    function automatic logic [7:0] sr(logic [1:0] p, logic w);
        return {4'h0, p, w, 1'b0};
    endfunction
    // ==========================================
    // checks and transfers
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] tx[$], input bit m3 = 0, input int h = -1);
        m_u.frame(m3, h, tx, rx);
    endtask
    task automatic sr_chk(logic [7:0] exp, bit m3 = 0, int h = -1);
        xfer({spiee_pkg::STATUS_READ_OP, rnd()}, m3, h);
        chk("status", exp, rx[1]);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < PROG + 40 && busy !== 1'b0; i++) @(posedge clock);
        #2;
        chk("idle", 8'h00, {7'h0, busy});
    endtask
    task automatic wr(logic [10:0] a, logic [7:0] dat, bit perm);
        xfer({spiee_pkg::SET_WRITE_LATCH_OP});
        xfer({spiee_pkg::ARRAY_WRITE_OP, (rnd() & 8'hF8) | {5'h0, a[10:8]}, a[7:0], dat});
        chk("busy", {7'h0, perm}, {7'h0, busy});
        if (perm) wait_idle();
    endtask
    task automatic rd(logic [10:0] a, int n);
        logic [7:0] q[$];
        q = {spiee_pkg::ARRAY_READ_OP, (rnd() & 8'hF8) | {5'h0, a[10:8]}, a[7:0]};
        repeat (n) q.push_back(rnd());
        xfer(q);
    endtask
    // ==========================================
    // main sequence
    initial begin
        fails = 0;
        n_compared = 0;
        srst = 1;
        wp_n = 1;
        repeat (3) @(posedge clock);
        #2 srst = 0;
        sr_chk(sr(2'h0, 1'b0));
        xfer({spiee_pkg::SET_WRITE_LATCH_OP});
        sr_chk(sr(2'h0, 1'b1), 1);
        xfer({spiee_pkg::ARRAY_WRITE_OP, rnd()});
        sr_chk(sr(2'h0, 1'b1));
        xfer({spiee_pkg::CLEAR_WRITE_LATCH_OP});
        sr_chk(sr(2'h0, 1'b0), 0, 1);
        for (int p = 0; p < 4; p++) begin
            bp = p[1:0];
            xfer({spiee_pkg::SET_WRITE_LATCH_OP});
            xfer({spiee_pkg::STATUS_WRITE_OP, (rnd() & 8'hF3) | {4'h0, bp, 2'h0}});
            xfer({spiee_pkg::STATUS_READ_OP, rnd()});
            chk("busy bit", 8'h01, rx[1] & 8'h01);
            wait_idle();
            sr_chk(sr(bp, 1'b0));
            foreach (addrs[k]) begin
                d = rnd();
                // first pass writes everything so that later reads have known data
                wp_n = (p == 0) || (d[1:0] != 2'h0);
                ok = wp_n && !prot(bp, addrs[k]);
                wr(addrs[k], d, ok);
                if (ok) mem[addrs[k]] = d;
                wp_n = 1;
            end
            foreach (addrs[k]) begin
                rd(addrs[k], 1);
                chk("array", mem[addrs[k]], rx[3]);
            end
        end
        rd(11'h7FF, 2);
        chk("wrap", mem[11'h000], rx[4]);
        close_out();
    end
    initial begin
        #600000;
        fails++;
        close_out();
    end
endmodule // testbench
